// ---- hw/fc_trigger.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - any-frame mode at FIFO level: jam on any received frame in half duplex, pause on reaching level in full duplex
// - full-duplex flow control only with any-frame bit and full duplex
// - half duplex any-frame: no address decode, jam on next preamble
// - full duplex any-frame: request pause at once on reaching level
// - pause waits for the next idle transmit slot, never cuts a frame
// - any-frame bit overrides multicast, broadcast and own-address bits
// - jam length from 4-bit code, 10 Mb/s adds 2.2 us
// - high level is 8 bits in 64-byte units, triggers the response
// - zero-time pause when FIFO drops below low level after a pause
// - one pause per high-level crossing, time from pause-time field
// - no pause and no jam while transmitter is disabled
module fc_trigger #(
   parameter int FIFO_BYTES_W = fc_pkg::FIFO_BYTES_W,
   parameter int UNIT_CYCLES = fc_pkg::BP_UNIT_CYCLES,
   parameter int TEN_EXTRA_CYCLES = fc_pkg::BP_TEN_EXTRA_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic any_frame_flow_trigger,
   input wire logic multicast_flow_trigger,
   input wire logic broadcast_flow_trigger,
   input wire logic own_address_flow_trigger,
   input wire logic [fc_pkg::CODE_W-1:0] backpressure_duration_code,
   input wire logic [fc_pkg::LEVEL_W-1:0] fifo_high_watermark,
   input wire logic [fc_pkg::LEVEL_W-1:0] fifo_low_watermark,
   input wire logic [fc_pkg::PAUSE_W-1:0] pause_time_value,
   input wire logic full_duplex,
   input wire logic speed_100,
   input wire logic tx_enable,
   input wire logic tx_frame_active,
   input wire logic [FIFO_BYTES_W-1:0] rx_fifo_used_bytes,
   input wire logic rx_preamble_valid,
   input wire logic rx_addr_valid,
   input wire logic rx_is_multicast,
   input wire logic rx_is_broadcast,
   input wire logic rx_is_own_address,
   output logic backpressure,
   output logic pause_req,
   output logic [fc_pkg::PAUSE_W-1:0] pause_time,
   output logic pause_armed
);
   // ***************************************************
   // parameter checks
   // ***************************************************
   generate
      if (FIFO_BYTES_W < fc_pkg::LEVEL_W + fc_pkg::LEVEL_UNIT_SHIFT) begin
         : g_bad_width
         $error("fifo byte count too narrow for watermarks");
      end
      if (UNIT_CYCLES < 1 || TEN_EXTRA_CYCLES < 0) begin : g_bad_time
         $error("backpressure cycle counts out of range");
      end
      if (longint'(fc_pkg::BP_UNITS_MAX) * UNIT_CYCLES + TEN_EXTRA_CYCLES
         >= (longint'(1) << fc_pkg::BP_CNT_W)) begin : g_bad_cnt
         $error("backpressure counter too narrow");
      end
   endgenerate

   // ***************************************************
   // level compare
   // ***************************************************
   wire [FIFO_BYTES_W-1:0] hi_bytes;
   wire [FIFO_BYTES_W-1:0] lo_bytes;
   wire reached;
   wire below_lo;

   assign hi_bytes = FIFO_BYTES_W'(fifo_high_watermark)
      << fc_pkg::LEVEL_UNIT_SHIFT;
   assign lo_bytes = FIFO_BYTES_W'(fifo_low_watermark)
      << fc_pkg::LEVEL_UNIT_SHIFT;
   assign reached = rx_fifo_used_bytes >= hi_bytes;
   assign below_lo = rx_fifo_used_bytes < lo_bytes;

   // ***************************************************
   // half duplex: jam triggers
   // ***************************************************
   wire hd_mode;
   wire hd_any_hit;
   wire addr_match;
   wire hd_addr_hit;
   wire jam_start;

   assign hd_mode = !full_duplex && tx_enable;
   // any-frame: no address decode, first preamble
   assign hd_any_hit = hd_mode && any_frame_flow_trigger && reached
      && rx_preamble_valid;
   assign addr_match = (multicast_flow_trigger && rx_is_multicast)
      || (broadcast_flow_trigger && rx_is_broadcast)
      || (own_address_flow_trigger && rx_is_own_address);
   assign hd_addr_hit = hd_mode && !any_frame_flow_trigger && reached
      && rx_addr_valid && addr_match;
   assign jam_start = hd_any_hit || hd_addr_hit;

   // ***************************************************
   // full duplex: pause scheduling
   // ***************************************************
   logic hi_sent_ff;
   logic nxt_hi_sent;
   logic pend_ff;
   logic nxt_pend;
   logic pend_zero_ff;
   logic nxt_pend_zero;
   logic pause_req_ff;
   logic nxt_pause_req;
   logic [fc_pkg::PAUSE_W-1:0] pause_time_ff;
   logic [fc_pkg::PAUSE_W-1:0] nxt_pause_time;
   logic jam_start_ff;
   wire fd_en;
   wire queue_hi;
   wire queue_zero;
   wire issue;

   assign fd_en = any_frame_flow_trigger && full_duplex;
   // one pause per crossing, re-armed by the zero pause
   assign queue_hi = fd_en && reached && !hi_sent_ff && !pend_ff;
   assign queue_zero = fd_en && hi_sent_ff && below_lo
      && !pend_ff;
   // wait for idle transmitter; nothing goes out while disabled
   assign issue = pend_ff && tx_enable && !tx_frame_active;

   assign nxt_pend = queue_hi || queue_zero || (pend_ff && !issue);
   assign nxt_pend_zero = queue_zero ? 1'b1
      : queue_hi ? 1'b0 : pend_zero_ff;
   assign nxt_hi_sent = queue_hi ? 1'b1
      : queue_zero ? 1'b0 : hi_sent_ff;
   assign nxt_pause_req = issue;
   assign nxt_pause_time = !issue ? pause_time_ff
      : pend_zero_ff ? fc_pkg::ZERO_PAUSE : pause_time_value;

   always_ff @(posedge clk) begin
      if (srst) begin
         hi_sent_ff <= 1'b0;
         pend_ff <= 1'b0;
         pend_zero_ff <= 1'b0;
         pause_req_ff <= 1'b0;
         pause_time_ff <= '0;
         jam_start_ff <= 1'b0;
      end else begin
         hi_sent_ff <= nxt_hi_sent;
         pend_ff <= nxt_pend;
         pend_zero_ff <= nxt_pend_zero;
         pause_req_ff <= nxt_pause_req;
         pause_time_ff <= nxt_pause_time;
         jam_start_ff <= jam_start;
      end
   end

   // ***************************************************
   // jam timer
   // ***************************************************
   bp_if bpi ();

   assign bpi.start = jam_start_ff;
   assign bpi.abort = !tx_enable;
   assign bpi.slow = !speed_100;
   assign bpi.code = backpressure_duration_code;

   bp_timer #(
      .UNIT_CYCLES(UNIT_CYCLES),
      .TEN_EXTRA_CYCLES(TEN_EXTRA_CYCLES)
   ) u_bp_timer (
      .clk(clk),
      .srst(srst),
      .t(bpi.tmr)
   );

   assign backpressure = bpi.busy;
   assign pause_req = pause_req_ff;
   assign pause_time = pause_time_ff;
   assign pause_armed = hi_sent_ff;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   AST_HD_ANY_JAM: assert property (
      hd_any_hit ##1 tx_enable |-> ##1 backpressure)
      else $error("no jam after preamble at level");
   AST_ADDR_JAM: assert property (
      hd_addr_hit ##1 tx_enable |-> ##1 backpressure)
      else $error("no jam after address match at level");
   AST_PULSE: assert property (
      pause_req |=> !pause_req)
      else $error("pause request longer than one cycle");
   AST_ZERO_TIME: assert property (
      pause_req && $past(pend_zero_ff) |-> pause_time == fc_pkg::ZERO_PAUSE)
      else $error("low-level pause time not zero");
   AST_HD_PREAMBLE: assert property (
      $rose(jam_start_ff) && any_frame_flow_trigger
      && $past(any_frame_flow_trigger) |-> $past(rx_preamble_valid))
      else $error("any-frame jam not started by preamble");
   AST_FD_ONLY: assert property (
      $rose(pend_ff) |-> $past(any_frame_flow_trigger && full_duplex))
      else $error("pause queued outside full-duplex any-frame");
   AST_FD_IMMEDIATE: assert property (
      fd_en && reached && !hi_sent_ff && !pend_ff |-> ##1 pend_ff)
      else $error("pause not queued at level");
   AST_NO_CUT: assert property (
      pause_req |-> $past(!tx_frame_active && pend_ff))
      else $error("pause issued during a frame");
   AST_OVERRIDE: assert property (
      any_frame_flow_trigger && !rx_preamble_valid |-> ##1 !jam_start_ff)
      else $error("address bits acted in any-frame mode");
   AST_HI_LEVEL: assert property (
      $rose(pend_ff) && !pend_zero_ff |-> $past(reached))
      else $error("pause queued below high level");
   AST_ZERO_PAUSE: assert property (
      $rose(pend_ff) && pend_zero_ff |-> $past(hi_sent_ff && below_lo))
      else $error("zero pause without prior pause");
   AST_ONE_PAUSE: assert property (
      $rose(pend_ff) && !pend_zero_ff |-> $past(!hi_sent_ff))
      else $error("second pause in one crossing");
   AST_PAUSE_TIME: assert property (
      pause_req && !$past(pend_zero_ff)
      |-> pause_time == $past(pause_time_value))
      else $error("pause time not from pause-time field");
   AST_TX_OFF: assert property (
      !tx_enable |-> ##1 (!pause_req && !backpressure))
      else $error("activity while transmitter disabled");
endmodule

// ---- pkg/fc_pkg.sv ----
package fc_pkg;
   // ***************************************************
   // levels, widths and timing
   // ***************************************************
   localparam int LEVEL_UNIT_SHIFT = 6; // 64-byte units
   localparam int LEVEL_W = 8;
   localparam int CODE_W = 4;
   localparam int PAUSE_W = 16;
   localparam int BP_CNT_W = 18;
   localparam int FIFO_BYTES_W = 14;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int BP_BASE_NS = 5000; // 5 us, code 0 at 100 Mb/s
   localparam int BP_TEN_EXTRA_NS = 2200; // 2.2 us longer at 10 Mb/s
   localparam int BP_UNIT_CYCLES = (BP_BASE_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int BP_TEN_EXTRA_CYCLES = (BP_TEN_EXTRA_NS * 1000
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // ***************************************************
   // duration per code, in 5 us units
   // ***************************************************
   typedef logic [7:0] bp_units_t [16];
   localparam bp_units_t BP_UNITS = '{
      8'h01, 8'h02, 8'h03, 8'h05, 8'h0A, 8'h14, 8'h1E, 8'h28,
      8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A, 8'h64, 8'h6E, 8'h78};
   localparam logic [7:0] BP_UNITS_MAX = 8'h78;
   localparam logic [PAUSE_W-1:0] ZERO_PAUSE = 16'h0000;
endpackage

// ---- pkg/bp_if.sv ----
`timescale 1ns/1ps
interface bp_if;
   logic start;
   logic abort;
   logic slow;
   logic [fc_pkg::CODE_W-1:0] code;
   logic busy;
   modport ctl (output start, output abort, output slow, output code,
      input busy);
   modport tmr (input start, input abort, input slow, input code,
      output busy);
endinterface

// ---- hw/bp_timer.sv ----
`timescale 1ns/1ps
module bp_timer #(
   parameter int UNIT_CYCLES = fc_pkg::BP_UNIT_CYCLES,
   parameter int TEN_EXTRA_CYCLES = fc_pkg::BP_TEN_EXTRA_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   bp_if.tmr t
);
   // ***************************************************
   // duration lookup and countdown
   // ***************************************************
   logic [fc_pkg::BP_CNT_W-1:0] count_ff;
   logic [fc_pkg::BP_CNT_W-1:0] nxt_count;
   logic busy_ff;
   logic nxt_busy;
   int load_int;
   wire [fc_pkg::BP_CNT_W-1:0] load;
   wire [fc_pkg::BP_CNT_W-1:0] extra;

   assign extra = t.slow ? fc_pkg::BP_CNT_W'(TEN_EXTRA_CYCLES)
      : '0;
   assign load_int = int'(fc_pkg::BP_UNITS[t.code]) * UNIT_CYCLES;
   assign load = fc_pkg::BP_CNT_W'(load_int) + extra;
   assign nxt_count = t.abort ? '0
      : t.start ? load
      : (count_ff != '0) ? count_ff - 1'b1 : count_ff;
   assign nxt_busy = nxt_count != '0;
   assign t.busy = busy_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         count_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         busy_ff <= nxt_busy;
      end
   end

   AST_BP_LOAD: assert property (@(posedge clk) disable iff (srst)
      t.start && !t.abort |=> count_ff == $past(load))
      else $error("backpressure length not loaded");
   AST_BP_CODE0: assert property (@(posedge clk) disable iff (srst)
      t.start && !t.abort && t.code == '0 && !t.slow
      |=> count_ff == fc_pkg::BP_CNT_W'(UNIT_CYCLES))
      else $error("code 0 length wrong");
endmodule

// ---- sim/mac_tx_model.sv ----
`timescale 1ns/1ps
// ********
// mac transmitter stand-in, pause frame takes 8 cycles
// ********
module mac_tx_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic send_frame,
   input wire logic [7:0] frame_len,
   input wire logic pause_req,
   output logic tx_frame_active,
   output int pause_count,
   output int cut_count
);
   int left;
   assign tx_frame_active = left != 0;
   always_ff @(posedge clk) begin
      if (srst) begin
         left <= 0;
         pause_count <= 0;
         cut_count <= 0;
      end else if (pause_req) begin
         pause_count <= pause_count + 1;
         cut_count <= cut_count + int'(tx_frame_active);
         left <= 8;
      end else if (send_frame) begin
         left <= int'(frame_len);
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
endmodule

// ---- sim/rx_fifo_flow_control_trigger_tb_top.sv ----
`timescale 1ns/1ps
module rx_fifo_flow_control_trigger_tb_top;
   localparam int UC = 4;
   localparam int TE = 2;
   logic clk, srst, any, mc, bc, own, fd, spd, txen, txa, pre, av;
   logic ismc, isbc, isown, send, bp, preq, armed;
   logic [3:0] code;
   logic [7:0] hi, lo, flen;
   logic [15:0] ptv, ptime;
   logic [13:0] used;
   logic [31:0] rng;
   int pcnt, ccnt, fail_count, checks_done;

   fc_trigger #(.UNIT_CYCLES(UC), .TEN_EXTRA_CYCLES(TE)) DUT (
      .clk(clk), .srst(srst), .any_frame_flow_trigger(any),
      .multicast_flow_trigger(mc), .broadcast_flow_trigger(bc),
      .own_address_flow_trigger(own), .backpressure_duration_code(code),
      .fifo_high_watermark(hi), .fifo_low_watermark(lo),
      .pause_time_value(ptv), .full_duplex(fd), .speed_100(spd),
      .tx_enable(txen), .tx_frame_active(txa), .rx_fifo_used_bytes(used),
      .rx_preamble_valid(pre), .rx_addr_valid(av), .rx_is_multicast(ismc),
      .rx_is_broadcast(isbc), .rx_is_own_address(isown),
      .backpressure(bp), .pause_req(preq), .pause_time(ptime),
      .pause_armed(armed));

   mac_tx_model mac (.clk(clk), .srst(srst), .send_frame(send),
      .frame_len(flen), .pause_req(preq), .tx_frame_active(txa),
      .pause_count(pcnt), .cut_count(ccnt));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic void roll();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
   endfunction

   // jam length in cycles for a code
   function automatic int jam_len(input logic [3:0] c, input logic s);
      int u;
      u = (c < 4) ? ((c == 3) ? 5 : int'(c) + 1) : (int'(c) - 3) * 10;
      return u * UC + (s ? 0 : TE);
   endfunction

   task automatic check(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic jam(input logic use_pre, input int exp_len);
      int n;
      n = 0;
      pre = use_pre;
      av = !use_pre;
      step();
      pre = 1'b0;
      av = 1'b0;
      step();
      while (bp === 1'b1 && n < 1000) begin
         n++;
         step();
      end
      check("jam_len", n, exp_len);
   endtask

   task automatic wait_pause(input logic [15:0] t);
      int n;
      n = 0;
      while (preq !== 1'b1 && n < 100) begin
         n++;
         step();
      end
      check("pause_seen", preq, 1'b1);
      check("pause_time", ptime, t);
      step();
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      rng = 32'h0000C8EB;
      fail_count = 0;
      checks_done = 0;
      {srst, any, mc, bc, own, fd, pre, av, send} = 9'h100;
      {ismc, isbc, isown, txen, spd} = 5'h03;
      code = 4'h0;
      flen = 8'h00;
      roll();
      hi = {1'b1, rng[6:0]};
      lo = 8'h08;
      ptv = rng[31:16];
      used = 14'h0000;
      step(4);
      srst = 1'b0;
      step();
      any = 1'b1;
      used = {hi, 6'h00};
      for (int c = 0; c < 16; c++) begin
         roll();
         code = 4'(c);
         spd = rng[0];
         {mc, bc, own, ismc, isbc, isown} = rng[6:1];
         jam(1'b1, jam_len(code, spd));
      end
      used = {hi, 6'h00} - 14'h0001;
      jam(1'b1, 0);
      used = {hi, 6'h00};
      {mc, bc, own, ismc, isbc, isown} = 6'h3F;
      jam(1'b0, 0);
      any = 1'b0;
      for (int i = 0; i < 3; i++) begin
         {mc, bc, own} = 3'(1 << i);
         {ismc, isbc, isown} = 3'(1 << i);
         jam(1'b0, jam_len(code, spd));
         {ismc, isbc, isown} = ~3'(1 << i);
         jam(1'b0, 0);
      end
      any = 1'b1;
      pre = 1'b1;
      step();
      pre = 1'b0;
      step(3);
      check("jam_on", bp, 1'b1);
      txen = 1'b0;
      step();
      check("jam_abort", bp, 1'b0);
      jam(1'b1, 0);
      txen = 1'b1;
      any = 1'b0;
      fd = 1'b1;
      step(6);
      check("fd_off", pcnt, 0);
      any = 1'b1;
      step(2);
      check("armed", armed, 1'b1);
      check("pause_now", preq, 1'b1);
      check("pause_val", ptime, ptv);
      step(30);
      check("one_pause", pcnt, 1);
      flen = 8'h28;
      send = 1'b1;
      step();
      send = 1'b0;
      used = {lo, 6'h00} - 14'h0001;
      step(3);
      check("no_cut", preq, 1'b0);
      wait_pause(16'h0000);
      check("disarmed", armed, 1'b0);
      roll();
      ptv = rng[15:0];
      txen = 1'b0;
      used = {hi, 6'h00};
      step(10);
      check("tx_off", pcnt, 2);
      txen = 1'b1;
      wait_pause(ptv);
      step(10);
      check("pauses", pcnt, 3);
      check("cuts", ccnt, 0);
      test_done();
   end
endmodule
